// ---- fcc_arr_if.sv ----
`timescale 1ns/1ps
interface fcc_arr_if;
  logic        start;
  logic [3:0]  op;
  logic [31:0] addr;
  logic [31:0] data;
  logic        busy;
  logic        done;
  modport ctrl (output start, output op, output addr, output data,
                input busy, input done);
  modport seq  (input start, input op, input addr, input data,
                output busy, output done);
endinterface : fcc_arr_if

// ---- fcc_defs.svh ----
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH

`define FCC_OFS_CMD       12'h008
`define FCC_OFS_ADDR      12'h000
`define FCC_OFS_DATA      12'h004
`define FCC_OFS_RAW       12'h00C
`define FCC_OFS_MASK      12'h010
`define FCC_OFS_MISC      12'h014

`define FCC_KEY_VALUE     16'hA442
`define FCC_KEY_HI        31
`define FCC_KEY_LO        16
`define FCC_BIT_WRITE     0
`define FCC_BIT_PAGE      1
`define FCC_BIT_MASS      2
`define FCC_BIT_COMMIT    3
`define FCC_BIT_PDONE     1

`define FCC_CLK_MHZ       200
`define FCC_T_WORD_US     50
`define FCC_T_COMMIT_US   50
`define FCC_T_PAGE_MS     25
`define FCC_T_MASS_MS     250
`define FCC_CYC_WORD      (`FCC_T_WORD_US * `FCC_CLK_MHZ)
`define FCC_CYC_COMMIT    (`FCC_T_COMMIT_US * `FCC_CLK_MHZ)
`define FCC_CYC_PAGE      (`FCC_T_PAGE_MS * 1000 * `FCC_CLK_MHZ)
`define FCC_CYC_MASS      (`FCC_T_MASS_MS * 1000 * `FCC_CLK_MHZ)

`endif

// ---- fcc_flash_model.sv ----
`timescale 1ns/1ps
module fcc_flash_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        arr_start,
  input  wire logic [3:0]  arr_op,
  input  wire logic [31:0] arr_addr,
  input  wire logic [31:0] arr_data,
  output int               starts,
  output logic [3:0]       last_op,
  output logic [31:0]      last_addr,
  output logic [31:0]      last_data
);
  // the array records each operation it is handed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      starts    <= 0;
      last_op   <= 4'h0;
      last_addr <= 32'h0;
      last_data <= 32'h0;
    end else if (arr_start) begin
      starts    <= starts + 1;
      last_op   <= arr_op;
      last_addr <= arr_addr;
      last_data <= arr_data;
    end
  end
endmodule : fcc_flash_model

// ---- fcc_monitor.sv ----
`timescale 1ns/1ps
module fcc_monitor #(
  parameter logic [31:0] CYC_WORD   = 32'h14,
  parameter logic [31:0] CYC_PAGE   = 32'h14,
  parameter logic [31:0] CYC_MASS   = 32'h14,
  parameter logic [31:0] CYC_COMMIT = 32'h14
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        arr_start,
  input wire logic [3:0]  arr_op
);
  logic [31:0] cnt_r;
  logic [31:0] lim;
  assign lim = arr_op[2] ? CYC_MASS : arr_op[1] ? CYC_PAGE :
               arr_op[3] ? CYC_COMMIT : CYC_WORD;
  // counts cycles of the running operation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= (arr_op == 4'h0) ? 32'h0 : cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_keyed;
    $past(s_axi_wdata[31:16]) == 16'hA442;
  endsequence
  sequence s_busy8;
    (arr_op != 4'h0)[*8];
  endsequence
  a_start_pulse: assert property (arr_start |=> !arr_start)
    else $error("start pulse too long");
  a_start_keyed: assert property (arr_start |-> s_keyed)
    else $error("start without key");
  a_start_resp: assert property (arr_start |-> s_axi_bvalid
    && s_axi_bresp == 2'b00)
    else $error("start not tied to write response");
  a_start_idle: assert property (arr_start |-> $onehot(arr_op)
    && $past(arr_op) == 4'h0)
    else $error("start while busy");
  a_op_hold: assert property (arr_op != 4'h0 |=>
    arr_op == $past(arr_op) || arr_op == 4'h0)
    else $error("operation changed midway");
  a_op_runs: assert property ($rose(|arr_op) |-> s_busy8)
    else $error("operation ended too soon");
  a_op_bound: assert property (cnt_r <= lim)
    else $error("operation overran its limit");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : fcc_monitor
bind fcc_top fcc_monitor #(.CYC_WORD(CYC_WORD), .CYC_PAGE(CYC_PAGE),
  .CYC_MASS(CYC_MASS), .CYC_COMMIT(CYC_COMMIT)) u_mon (
  .clock(clock), .rst_n(rst_n), .s_axi_wdata(s_axi_wdata),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .arr_start(arr_start), .arr_op(arr_op));

// ---- fcc_pkg.sv ----
package fcc_pkg;
  typedef enum logic [4:0] {
    FCC_IDLE   = 5'b00001,
    FCC_WORD   = 5'b00010,
    FCC_PAGE   = 5'b00100,
    FCC_MASS   = 5'b01000,
    FCC_COMMIT = 5'b10000
  } fcc_op_t;
endpackage : fcc_pkg

// ---- fcc_tb_top.sv ----
`timescale 1ns/1ps
`include "fcc_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module fcc_tb_top;
  logic clock = 1'b0, rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, arr_addr, arr_data, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, arr_start;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, bq;
  logic [3:0] arr_op, last_op;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] last_addr, last_data, ea, ed;
  int failures = 0, cmp_count = 0, cyc = 0, lag = 0, starts, i, n, t0;
  always #2.5 clock = ~clock;
  fcc_top #(.CYC_WORD(32'h14), .CYC_PAGE(32'h14), .CYC_MASS(32'h14),
    .CYC_COMMIT(32'h14)) uut (
    .clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq), .arr_start(arr_start), .arr_op(arr_op),
    .arr_addr(arr_addr), .arr_data(arr_data));
  fcc_flash_model fm (
    .clock(clock), .rst_n(rst_n), .arr_start(arr_start),
    .arr_op(arr_op), .arr_addr(arr_addr), .arr_data(arr_data),
    .starts(starts), .last_op(last_op), .last_addr(last_addr),
    .last_data(last_data));
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v; s_axi_wvalid <= 1'b1; s_axi_bready <= (lag == 0);
    do begin
      @(posedge clock);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (k >= lag && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    bq = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int k;
    k = 0;
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= (lag == 0);
    do begin
      @(posedge clock);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (k >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(`FCC_OFS_CMD); `CHK(d, 32'h0)
    lag = 3;
    wr(`FCC_OFS_CMD, 32'h1234_0001);
    `CHK(bq, 2'b00)
    rd(12'h800); `CHK(r, 2'b10)
    wr(12'h800, 32'h0); `CHK(bq, 2'b10)
    lag = 0;
    wr(`FCC_OFS_CMD, {`FCC_KEY_VALUE, 16'h0000});
    rd(`FCC_OFS_CMD); `CHK(d, 32'h0)
    `CHK(starts, 0)
    for (i = 0; i < 4; i++) begin
      ea = 32'h0000_0400 + 32'(i * 4);
      ed = 32'hC0DE_0000 + 32'(i);
      if (i == 1) wr(`FCC_OFS_MASK, 32'h2);
      wr(`FCC_OFS_ADDR, ea);
      wr(`FCC_OFS_DATA, ed);
      wr(`FCC_OFS_CMD, {`FCC_KEY_VALUE, 12'h000, 4'(1 << i)});
      t0 = cyc;
      rd(`FCC_OFS_CMD); `CHK(d, 32'(1 << i))
      `CHK(last_op, 4'(1 << i))
      `CHK(last_addr, ea)
      `CHK(last_data, ed)
      n = 0;
      do begin
        rd(`FCC_OFS_CMD);
        n++;
      end while (d !== 32'h0 && n < 20);
      `CHK(d, 32'h0)
      `CHK(cyc - t0 <= 32, 1'b1)
      `CHK(cyc - t0 >= 19, 1'b1)
      rd(`FCC_OFS_RAW); `CHK(d, (i == 3) ? 32'h0 : 32'h2)
      `CHK(irq, i == 1 || i == 2)
      wr(`FCC_OFS_MISC, 32'h2);
      rd(`FCC_OFS_RAW); `CHK(d, 32'h0)
      `CHK(irq, 1'b0)
    end
    `CHK(starts, 4)
    results();
  end
endmodule : fcc_tb_top

// ---- fcc_timer.sv ----
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_timer
  import fcc_pkg::*;
#(
  parameter logic [31:0] CYC_WORD   = `FCC_CYC_WORD,
  parameter logic [31:0] CYC_PAGE   = `FCC_CYC_PAGE,
  parameter logic [31:0] CYC_MASS   = `FCC_CYC_MASS,
  parameter logic [31:0] CYC_COMMIT = `FCC_CYC_COMMIT
) (
  input wire logic clock,
  input wire logic rst_n,
  fcc_arr_if.seq   arr
);
  typedef struct packed {
    fcc_op_t     st;
    logic [31:0] cnt;
    logic        done;
  } fcc_tmr_t;

  fcc_tmr_t s_r;
  fcc_tmr_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      FCC_IDLE: begin
        if (arr.start) begin
          s_nxt.cnt = 32'h1;
          if (arr.op[`FCC_BIT_COMMIT]) s_nxt.st = FCC_COMMIT;
          else if (arr.op[`FCC_BIT_MASS]) s_nxt.st = FCC_MASS;
          else if (arr.op[`FCC_BIT_PAGE]) s_nxt.st = FCC_PAGE;
          else s_nxt.st = FCC_WORD;
        end
      end
      FCC_WORD, FCC_PAGE, FCC_MASS, FCC_COMMIT: begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        // start and clear latency take two cycles of the budget
        if ((s_r.st == FCC_WORD && s_r.cnt >= CYC_WORD - 32'h2) ||
            (s_r.st == FCC_PAGE && s_r.cnt >= CYC_PAGE - 32'h2) ||
            (s_r.st == FCC_MASS && s_r.cnt >= CYC_MASS - 32'h2) ||
            (s_r.st == FCC_COMMIT && s_r.cnt >= CYC_COMMIT - 32'h2)) begin
          s_nxt.st   = FCC_IDLE;
          s_nxt.cnt  = 32'h0;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = FCC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: FCC_IDLE, cnt: 32'h0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign arr.busy = (s_r.st != FCC_IDLE);
  assign arr.done = s_r.done;
endmodule : fcc_timer

// ---- fcc_top.sv ----
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_top
  import fcc_pkg::*;
#(
  parameter logic [31:0] CYC_WORD   = `FCC_CYC_WORD,
  parameter logic [31:0] CYC_PAGE   = `FCC_CYC_PAGE,
  parameter logic [31:0] CYC_MASS   = `FCC_CYC_MASS,
  parameter logic [31:0] CYC_COMMIT = `FCC_CYC_COMMIT
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             arr_start,
  output logic [3:0]       arr_op,
  output logic [31:0]      arr_addr,
  output logic [31:0]      arr_data
);
  typedef struct packed {
    logic        aw_got;
    logic [11:0] aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  cmd;
    logic        start;
    logic        pdone;
    logic        pmask;
  } fcc_regs_t;

  fcc_regs_t s_r;
  fcc_regs_t s_nxt;
  fcc_arr_if arr ();

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction : strb_merge

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `FCC_OFS_ADDR) || (a == `FCC_OFS_DATA) ||
             (a == `FCC_OFS_CMD)  || (a == `FCC_OFS_RAW)  ||
             (a == `FCC_OFS_MASK) || (a == `FCC_OFS_MISC);
  endfunction : mapped

  fcc_timer #(
    .CYC_WORD   (CYC_WORD),
    .CYC_PAGE   (CYC_PAGE),
    .CYC_MASS   (CYC_MASS),
    .CYC_COMMIT (CYC_COMMIT)
  ) u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .arr   (arr.seq)
  );

  assign arr.start = s_r.start;
  assign arr.op    = s_r.cmd;
  assign arr.addr  = s_r.addr;
  assign arr.data  = s_r.data;

  logic        do_wr;
  logic [11:0] wa;
  logic [31:0] wd;
  logic        key_ok;
  logic [3:0]  new_cmd;
  logic        clr_pdone;
  logic [31:0] rd;

  assign wa     = s_r.aw_got ? s_r.aw_addr : s_axi_awaddr;
  assign wd     = s_r.w_got ? s_r.w_data : s_axi_wdata;
  assign do_wr  = (s_r.aw_got || s_axi_awvalid) &&
                  (s_r.w_got || s_axi_wvalid) && !s_r.bvalid;
  assign key_ok = (wd[`FCC_KEY_HI:`FCC_KEY_LO] == `FCC_KEY_VALUE)
                  && (s_r.w_got ? (&s_r.w_strb) : (&s_axi_wstrb));
  assign new_cmd = wd[3:0];
  assign clr_pdone = do_wr && (wa == `FCC_OFS_MISC)
                     && wd[`FCC_BIT_PDONE];

  always_comb begin
    rd = 32'h0;
    if (s_axi_araddr == `FCC_OFS_ADDR) rd = s_r.addr;
    else if (s_axi_araddr == `FCC_OFS_DATA) rd = s_r.data;
    else if (s_axi_araddr == `FCC_OFS_CMD)
      rd = {16'h0, 12'h0, s_r.cmd};
    else if (s_axi_araddr == `FCC_OFS_RAW)
      rd = {30'h0, s_r.pdone, 1'b0};
    else if (s_axi_araddr == `FCC_OFS_MASK)
      rd = {30'h0, s_r.pmask, 1'b0};
    else if (s_axi_araddr == `FCC_OFS_MISC)
      rd = {30'h0, s_r.pdone & s_r.pmask, 1'b0};
  end

  always_comb begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    if (s_axi_awvalid && s_axi_awready && !do_wr) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !do_wr) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = mapped(wa) ? 2'h0 : 2'h2;
      if (wa == `FCC_OFS_ADDR && !arr.busy)
        s_nxt.addr = strb_merge(s_r.addr, wd,
                                s_r.w_got ? s_r.w_strb : s_axi_wstrb);
      if (wa == `FCC_OFS_DATA && !arr.busy)
        s_nxt.data = strb_merge(s_r.data, wd,
                                s_r.w_got ? s_r.w_strb : s_axi_wstrb);
      if (wa == `FCC_OFS_MASK)
        s_nxt.pmask = wd[`FCC_BIT_PDONE];
      if (wa == `FCC_OFS_CMD && key_ok && (new_cmd != 4'h0)
          && s_r.cmd == 4'h0 && !arr.busy) begin
        // highest bit wins if several are set at once
        if (new_cmd[`FCC_BIT_COMMIT])
          s_nxt.cmd = 4'b1000;
        else if (new_cmd[`FCC_BIT_MASS])
          s_nxt.cmd = 4'b0100;
        else if (new_cmd[`FCC_BIT_PAGE])
          s_nxt.cmd = 4'b0010;
        else
          s_nxt.cmd = 4'b0001;
        s_nxt.start = 1'b1;
      end
    end
    if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd;
      s_nxt.rresp  = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (clr_pdone) s_nxt.pdone = 1'b0;
    if (arr.done) begin
      s_nxt.cmd = 4'h0;
      if (!s_r.cmd[`FCC_BIT_COMMIT])
        s_nxt.pdone = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign irq           = s_r.pdone & s_r.pmask;
  assign arr_start     = s_r.start;
  assign arr_op        = s_r.cmd;
  assign arr_addr      = s_r.addr;
  assign arr_data      = s_r.data;
endmodule : fcc_top
